// file: hdl/shelf_pkg.sv
// constants and types shared by the shelf management logic
package shelf_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_FREQ_MHZ = 50;
	localparam int START_SETTLE_US = 100;
	localparam int BLINK_STEP_MS = 100;
	localparam int START_SETTLE_CYCLES_DEF = START_SETTLE_US * CLK_FREQ_MHZ;
	localparam int BLINK_STEP_CYCLES_DEF = BLINK_STEP_MS * 1000 * CLK_FREQ_MHZ;

	// ==========================================================
	// blink pattern: six steps per period
	localparam logic [2:0] BLINK_LAST_PHASE = 3'h5;
	localparam logic [2:0] BLINK_HALF_END = 3'h3;
	localparam logic [2:0] BLINK_TWO_THIRDS_END = 3'h4;

	// ==========================================================
	// bus addresses, 8-bit form with bit 0 as direction
	localparam logic [7:0] CTRL_ADDR_BASE = 8'h50;
	localparam logic [7:0] MUX_ADDR_BASE = 8'hE0;
	localparam logic [7:0] MUX_CONTROL_RESET = 8'h00;

	// ==========================================================
	// command codes and values
	localparam logic [7:0] CMD_SHELF_ON_OFF = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_CONFIGURATION = 8'h02;
	localparam logic [7:0] SHELF_OFF = 8'h00;
	localparam logic [7:0] SHELF_ON = 8'h80;
	localparam logic [7:0] SHELF_ON_OFF_RESET = 8'h80;
	localparam logic [7:0] ON_OFF_CFG_RESET = 8'h19;
	localparam logic [7:0] ON_OFF_CFG_ALT_A = 8'h01;
	localparam logic [7:0] ON_OFF_CFG_ALT_B = 8'h11;
	localparam logic [7:0] ON_OFF_CFG_ALT_C = 8'h15;
	localparam logic [7:0] ON_OFF_CFG_ALT_D = 8'h1D;
	localparam int CFG_CONTROLLED_BIT = 4;
	localparam int CFG_USE_COMMAND_BIT = 3;
	localparam int CFG_USE_PIN_BIT = 2;
	localparam logic [7:0] READ_FILL = 8'hFF;

	// ==========================================================
	// link byte framing
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_CMD,
		LINK_WDATA,
		LINK_READ,
		LINK_WAIT_STOP
	} link_state_e;

endpackage

// file: hdl/module_led_driver.sv
// status lamp driver for one power module
`timescale 1ns/1ps
`default_nettype none

module module_led_driver (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// module state
	input wire logic ac_ok,
	input wire logic enable_n,
	input wire logic power_good_n,
	input wire logic out_of_regulation,
	input wire logic shutdown,
	input wire logic ot_warning,
	input wire logic fan_minor_error,
	// blink phases
	input wire logic blink_half,
	input wire logic blink_two_thirds,
	// lamps
	output logic ac_green,
	output logic dc_green,
	output logic dc_yellow
);

	logic next_ac_green;
	logic next_dc_green;
	logic next_dc_yellow;
	logic normal;

	// ==========================================================
	// lamp selection
	always_comb begin
		normal = !power_good_n && !enable_n && !out_of_regulation && !shutdown
			&& !ot_warning && !fan_minor_error;
		next_ac_green = ac_ok;
		next_dc_green = 1'b0;
		next_dc_yellow = 1'b0;
		// first match wins, tested in this order
		if (normal) begin
			next_dc_green = 1'b1;
		end else if (enable_n) begin
			next_dc_yellow = blink_half;
		end else if (out_of_regulation || shutdown) begin
			next_dc_yellow = 1'b1;
		end else if (ot_warning) begin
			next_dc_yellow = blink_two_thirds;
			next_dc_green = !blink_two_thirds;
		end else if (fan_minor_error) begin
			next_dc_yellow = blink_half;
			next_dc_green = !blink_half;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ac_green <= 1'b0;
			dc_green <= 1'b0;
			dc_yellow <= 1'b0;
		end else begin
			ac_green <= next_ac_green;
			dc_green <= next_dc_green;
			dc_yellow <= next_dc_yellow;
		end
	end

endmodule // module_led_driver

`default_nettype wire

// file: hdl/power_shelf_management_logic.sv
// shelf management: status aggregation, enable, bus commands, lamps
`timescale 1ns/1ps
`default_nettype none

module power_shelf_management_logic import shelf_pkg::*; #(
	parameter int NUM_MODULES = 6,
	parameter int START_SETTLE_CYCLES = START_SETTLE_CYCLES_DEF,
	parameter int BLINK_STEP_CYCLES = BLINK_STEP_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// management link, open drain data
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// shelf pins
	input wire logic shelf_enable_n,
	input wire logic [2:0] address_select_switch,
	output logic power_good_n,
	output logic input_good_n,
	output logic shelf_alert_n,
	output logic shelf_fault_latched,
	output logic [7:0] mux_channel_control,
	// per module status
	input wire logic [NUM_MODULES-1:0] module_power_good_n,
	input wire logic [NUM_MODULES-1:0] module_alert_n,
	input wire logic [NUM_MODULES-1:0] module_input_good_n,
	input wire logic [NUM_MODULES-1:0] module_ac_ok,
	input wire logic [NUM_MODULES-1:0] module_out_of_regulation,
	input wire logic [NUM_MODULES-1:0] module_ot_shutdown,
	input wire logic [NUM_MODULES-1:0] module_ov_shutdown,
	input wire logic [NUM_MODULES-1:0] module_uv_shutdown,
	input wire logic [NUM_MODULES-1:0] module_oc_shutdown,
	input wire logic [NUM_MODULES-1:0] module_ot_warning,
	input wire logic [NUM_MODULES-1:0] module_fan_minor_error,
	// per module control and lamps
	output logic [NUM_MODULES-1:0] module_enable_n,
	output logic [NUM_MODULES-1:0] led_ac_green,
	output logic [NUM_MODULES-1:0] led_dc_green,
	output logic [NUM_MODULES-1:0] led_dc_yellow
);

	localparam int PIN_W = 6 + 11 * NUM_MODULES;
	localparam int SETTLE_W = $clog2(START_SETTLE_CYCLES + 1);
	localparam int STEP_W = $clog2(BLINK_STEP_CYCLES + 1);
	// idle pin levels: a zero reset would fake a link edge and glitch the status outputs
	localparam logic [PIN_W-1:0] PIN_IDLE = {{(6 + 3 * NUM_MODULES){1'b1}}, {(8 * NUM_MODULES){1'b0}}};

	// ==========================================================
	// pin synchronisers
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic scl_s;
	logic sda_s;
	logic enable_n_s;
	logic [2:0] switch_s;
	logic [NUM_MODULES-1:0] pg_n_s;
	logic [NUM_MODULES-1:0] alert_n_s;
	logic [NUM_MODULES-1:0] ig_n_s;
	logic [NUM_MODULES-1:0] ac_ok_s;
	logic [NUM_MODULES-1:0] oor_s;
	logic [NUM_MODULES-1:0] ots_s;
	logic [NUM_MODULES-1:0] ovs_s;
	logic [NUM_MODULES-1:0] uvs_s;
	logic [NUM_MODULES-1:0] ocs_s;
	logic [NUM_MODULES-1:0] otw_s;
	logic [NUM_MODULES-1:0] fan_s;

	assign pin_raw = {scl_in, sda_in, shelf_enable_n, address_select_switch,
		module_power_good_n, module_alert_n, module_input_good_n, module_ac_ok,
		module_out_of_regulation, module_ot_shutdown, module_ov_shutdown,
		module_uv_shutdown, module_oc_shutdown, module_ot_warning, module_fan_minor_error};
	assign {scl_s, sda_s, enable_n_s, switch_s, pg_n_s, alert_n_s, ig_n_s, ac_ok_s,
		oor_s, ots_s, ovs_s, uvs_s, ocs_s, otw_s, fan_s} = pin_sync;

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_meta <= PIN_IDLE;
			pin_sync <= PIN_IDLE;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// link slave: controller commands and multiplexer control
	link_state_e state, next_state;
	logic [3:0] bit_count, next_bit_count;
	logic [7:0] shift, next_shift;
	logic [7:0] command, next_command;
	logic to_mux, next_to_mux;
	logic is_read, next_is_read;
	logic master_ack, next_master_ack;
	logic next_sda_oe;
	logic scl_prev;
	logic sda_prev;
	logic [7:0] shelf_on_off_command, next_shelf_on_off_command;
	logic [7:0] on_off_configuration, next_on_off_configuration;
	logic [7:0] next_mux_channel_control;
	logic [7:0] ctrl_addr;
	logic [7:0] mux_addr;
	logic [7:0] read_byte;
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;
	logic cfg_supported;

	assign ctrl_addr = {CTRL_ADDR_BASE[7:4], switch_s, 1'b0};
	assign mux_addr = {MUX_ADDR_BASE[7:4], switch_s, 1'b0};
	assign start_cond = scl_s && scl_prev && sda_prev && !sda_s;
	assign stop_cond = scl_s && scl_prev && !sda_prev && sda_s;
	assign scl_rise = scl_s && !scl_prev;
	assign scl_fall = !scl_s && scl_prev;
	assign cfg_supported = (shift == ON_OFF_CFG_RESET) || (shift == ON_OFF_CFG_ALT_A)
		|| (shift == ON_OFF_CFG_ALT_B) || (shift == ON_OFF_CFG_ALT_C)
		|| (shift == ON_OFF_CFG_ALT_D);
	assign read_byte = to_mux ? mux_channel_control
		: (command == CMD_SHELF_ON_OFF) ? shelf_on_off_command
		: (command == CMD_ON_OFF_CONFIGURATION) ? on_off_configuration : READ_FILL;

	always_comb begin
		next_state = state;
		next_bit_count = bit_count;
		next_shift = shift;
		next_command = command;
		next_to_mux = to_mux;
		next_is_read = is_read;
		next_master_ack = master_ack;
		next_sda_oe = sda_oe;
		next_shelf_on_off_command = shelf_on_off_command;
		next_on_off_configuration = on_off_configuration;
		next_mux_channel_control = mux_channel_control;
		if (start_cond) begin
			// repeated start keeps the command byte for a following read
			next_state = LINK_ADDR;
			next_bit_count = '0;
			next_sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_state = LINK_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			if (state == LINK_READ) begin
				if (bit_count < BYTE_BITS) begin
					next_shift = {shift[6:0], 1'b1};
					next_bit_count = bit_count + 4'h1;
				end else if (bit_count == ACK_SLOT) begin
					next_master_ack = !sda_s;
				end
			end else if (state != LINK_IDLE && state != LINK_WAIT_STOP
				&& bit_count < BYTE_BITS) begin
				next_shift = {shift[6:0], sda_s};
				next_bit_count = bit_count + 4'h1;
			end
		end else if (scl_fall) begin
			case (state)
				LINK_ADDR: begin
					if (bit_count == BYTE_BITS) begin
						next_is_read = shift[0];
						next_to_mux = (shift[7:1] == mux_addr[7:1]);
						if (shift[7:1] == mux_addr[7:1] || shift[7:1] == ctrl_addr[7:1]) begin
							next_sda_oe = 1'b1;
							next_bit_count = ACK_SLOT;
						end else begin
							next_state = LINK_WAIT_STOP;
						end
					end else if (bit_count == ACK_SLOT) begin
						next_bit_count = '0;
						if (is_read) begin
							next_state = LINK_READ;
							next_shift = read_byte;
							next_sda_oe = !read_byte[7];
						end else begin
							next_sda_oe = 1'b0;
							next_state = to_mux ? LINK_WDATA : LINK_CMD;
						end
					end
				end
				LINK_CMD: begin
					if (bit_count == BYTE_BITS) begin
						if (shift == CMD_SHELF_ON_OFF || shift == CMD_ON_OFF_CONFIGURATION) begin
							next_command = shift;
							next_sda_oe = 1'b1;
							next_bit_count = ACK_SLOT;
						end else begin
							next_command = READ_FILL;
							next_state = LINK_WAIT_STOP;
						end
					end else if (bit_count == ACK_SLOT) begin
						next_sda_oe = 1'b0;
						next_bit_count = '0;
						next_state = LINK_WDATA;
					end
				end
				LINK_WDATA: begin
					if (bit_count == BYTE_BITS) begin
						next_bit_count = ACK_SLOT;
						next_sda_oe = 1'b1;
						if (to_mux) begin
							next_mux_channel_control = shift;
						end else if (command == CMD_SHELF_ON_OFF
							&& (shift == SHELF_OFF || shift == SHELF_ON)) begin
							next_shelf_on_off_command = shift;
						end else if (command == CMD_ON_OFF_CONFIGURATION && cfg_supported) begin
							next_on_off_configuration = shift;
						end else begin
							next_sda_oe = 1'b0;
							next_state = LINK_WAIT_STOP;
						end
					end else if (bit_count == ACK_SLOT) begin
						// one data byte per frame; later bytes are refused
						next_sda_oe = 1'b0;
						next_state = LINK_WAIT_STOP;
					end
				end
				LINK_READ: begin
					if (bit_count == BYTE_BITS) begin
						next_sda_oe = 1'b0;
						next_bit_count = ACK_SLOT;
					end else if (bit_count == ACK_SLOT) begin
						if (master_ack) begin
							next_shift = read_byte;
							next_sda_oe = !read_byte[7];
							next_bit_count = '0;
						end else begin
							next_state = LINK_WAIT_STOP;
						end
					end else begin
						next_sda_oe = !shift[7];
					end
				end
				default: begin
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= LINK_IDLE;
			bit_count <= '0;
			shift <= '0;
			command <= READ_FILL;
			to_mux <= 1'b0;
			is_read <= 1'b0;
			master_ack <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			shelf_on_off_command <= SHELF_ON_OFF_RESET;
			on_off_configuration <= ON_OFF_CFG_RESET;
			mux_channel_control <= MUX_CONTROL_RESET;
		end else begin
			state <= next_state;
			bit_count <= next_bit_count;
			shift <= next_shift;
			command <= next_command;
			to_mux <= next_to_mux;
			is_read <= next_is_read;
			master_ack <= next_master_ack;
			sda_oe <= next_sda_oe;
			sda_out <= 1'b0;
			scl_prev <= scl_s;
			sda_prev <= sda_s;
			shelf_on_off_command <= next_shelf_on_off_command;
			on_off_configuration <= next_on_off_configuration;
			mux_channel_control <= next_mux_channel_control;
		end
	end

	// ==========================================================
	// shelf control: enable, fault latch, common start, blink timebase
	logic enable_n_prev;
	logic next_shelf_fault_latched;
	logic started, next_started;
	logic [SETTLE_W-1:0] settle_count, next_settle_count;
	logic [STEP_W-1:0] step_count, next_step_count;
	logic [2:0] blink_phase, next_blink_phase;
	logic [NUM_MODULES-1:0] next_module_enable_n;
	logic shelf_on;
	logic any_input_good;
	logic any_shutdown;

	assign any_input_good = !(&ig_n_s);
	assign any_shutdown = |(ots_s | ovs_s | uvs_s | ocs_s);

	always_comb begin
		// pin is ignored unless the configuration asks for it
		shelf_on = !on_off_configuration[CFG_CONTROLLED_BIT]
			|| ((!on_off_configuration[CFG_USE_COMMAND_BIT]
				|| shelf_on_off_command == SHELF_ON)
			&& (!on_off_configuration[CFG_USE_PIN_BIT] || !enable_n_s));
		next_shelf_fault_latched = shelf_fault_latched;
		if (enable_n_prev && !enable_n_s) begin
			next_shelf_fault_latched = 1'b0;
		end
		if (any_shutdown) begin
			next_shelf_fault_latched = 1'b1;
		end
		// hold every module off until input settles, then start them at once
		next_started = started;
		next_settle_count = settle_count;
		if (!any_input_good) begin
			next_started = 1'b0;
			next_settle_count = '0;
		end else if (!started) begin
			if (settle_count >= SETTLE_W'(START_SETTLE_CYCLES)) begin
				next_started = 1'b1;
			end else begin
				next_settle_count = settle_count + 1'b1;
			end
		end
		next_module_enable_n = {NUM_MODULES{!(shelf_on && started && !shelf_fault_latched)}};
		next_step_count = step_count + 1'b1;
		next_blink_phase = blink_phase;
		if (step_count >= STEP_W'(BLINK_STEP_CYCLES - 1)) begin
			next_step_count = '0;
			next_blink_phase = (blink_phase == BLINK_LAST_PHASE) ? 3'h0 : blink_phase + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			enable_n_prev <= 1'b1;
			shelf_fault_latched <= 1'b0;
			started <= 1'b0;
			settle_count <= '0;
			step_count <= '0;
			blink_phase <= '0;
			module_enable_n <= '1;
			power_good_n <= 1'b1;
			input_good_n <= 1'b1;
			shelf_alert_n <= 1'b1;
		end else begin
			enable_n_prev <= enable_n_s;
			shelf_fault_latched <= next_shelf_fault_latched;
			started <= next_started;
			settle_count <= next_settle_count;
			step_count <= next_step_count;
			blink_phase <= next_blink_phase;
			module_enable_n <= next_module_enable_n;
			power_good_n <= &pg_n_s;
			input_good_n <= &ig_n_s;
			shelf_alert_n <= &alert_n_s;
		end
	end

	// ==========================================================
	// per module lamps
	generate
		for (genvar m = 0; m < NUM_MODULES; m++) begin : g_led
			module_led_driver u_led (
				.clk(clk),
				.reset(reset),
				.ac_ok(ac_ok_s[m]),
				.enable_n(module_enable_n[m]),
				.power_good_n(pg_n_s[m]),
				.out_of_regulation(oor_s[m]),
				.shutdown(ots_s[m] | ovs_s[m] | uvs_s[m] | ocs_s[m]),
				.ot_warning(otw_s[m]),
				.fan_minor_error(fan_s[m]),
				.blink_half(blink_phase < BLINK_HALF_END),
				.blink_two_thirds(blink_phase < BLINK_TWO_THIRDS_END),
				.ac_green(led_ac_green[m]),
				.dc_green(led_dc_green[m]),
				.dc_yellow(led_dc_yellow[m])
			);
		end
	endgenerate

endmodule // power_shelf_management_logic

`default_nettype wire

// file: tb/power_shelf_monitor.sv
// assertions on the shelf management ports
`timescale 1ns/1ps
`default_nettype none

module power_shelf_monitor #(
	parameter int NUM_MODULES = 6
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// shelf pins
	input wire logic power_good_n,
	input wire logic input_good_n,
	input wire logic shelf_alert_n,
	input wire logic shelf_fault_latched,
	// per module
	input wire logic [NUM_MODULES-1:0] module_power_good_n,
	input wire logic [NUM_MODULES-1:0] module_alert_n,
	input wire logic [NUM_MODULES-1:0] module_input_good_n,
	input wire logic [NUM_MODULES-1:0] module_ac_ok,
	input wire logic [NUM_MODULES-1:0] module_ot_shutdown,
	input wire logic [NUM_MODULES-1:0] module_enable_n,
	input wire logic [NUM_MODULES-1:0] led_ac_green,
	input wire logic [NUM_MODULES-1:0] led_dc_green,
	input wire logic [NUM_MODULES-1:0] led_dc_yellow
);
	// ==========================================
	// edges since reset: the status pipeline is three deep
	logic [2:0] settle;
	logic [2:0] next_settle;
	always_comb begin
		next_settle = settle;
		if (reset)
			next_settle = 3'h0;
		else if (settle != 3'h4)
			next_settle = settle + 3'h1;
	end
	always_ff @(posedge clk) begin
		settle <= next_settle;
	end

	// ==========================================
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence no_input_s;
		(&module_input_good_n) [*6];
	endsequence
	sequence ac_steady_s;
		$stable(module_ac_ok) [*6];
	endsequence
	sequence fault_held_s;
		shelf_fault_latched [*2];
	endsequence
	chk_pg_wired_or: assert property (settle == 3'h4 |->
		power_good_n == &$past(module_power_good_n, 3)) else $error("power good mismatch");
	chk_alert_wired_or: assert property (settle == 3'h4 |->
		shelf_alert_n == &$past(module_alert_n, 3)) else $error("alert mismatch");
	chk_inok_wired_or: assert property (settle == 3'h4 |->
		input_good_n == &$past(module_input_good_n, 3)) else $error("input good mismatch");
	chk_enable_common: assert property (
		module_enable_n == '0 || module_enable_n == '1) else $error("modules start apart");
	chk_no_input_off: assert property (no_input_s |-> &module_enable_n)
		else $error("module enabled without good input");
	chk_fault_sets: assert property (|module_ot_shutdown |-> ##[1:4] shelf_fault_latched)
		else $error("shutdown not latched");
	chk_fault_forces_off: assert property (fault_held_s |-> &module_enable_n)
		else $error("module enabled during latched fault");
	chk_ac_lamp: assert property (ac_steady_s |-> led_ac_green == module_ac_ok)
		else $error("ac lamp mismatch");
	chk_lamp_one_colour: assert property (!(|(led_dc_green & led_dc_yellow)))
		else $error("dc lamp both colours");
endmodule // power_shelf_monitor

`default_nettype wire

// file: tb/management_host_model.sv
// management host model, bus master of the shelf link
`timescale 1ns/1ps
`default_nettype none

module management_host_model (
	// clock
	input wire logic clk,
	// link pins
	output logic scl,
	output logic sda_pull,
	input wire logic sda_line
);
	// ==========================================
	// bit level: 160 ns period, low 5 clocks so the ack release lands first
	logic acked;
	logic [7:0] rdata;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		acked = 1'b1;
		rdata = 8'h00;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic bit_cycle(input logic b, output logic r);
		wait_clk(2);
		sda_pull = !b;
		wait_clk(3);
		scl = 1'b1;
		wait_clk(2);
		r = sda_line;
		wait_clk(1);
		scl = 1'b0;
	endtask
	task automatic start();
		sda_pull = 1'b0;
		wait_clk(6);
		scl = 1'b1;
		wait_clk(4);
		sda_pull = 1'b1;
		wait_clk(4);
		scl = 1'b0;
	endtask
	task automatic stop();
		wait_clk(2);
		sda_pull = 1'b1;
		wait_clk(4);
		scl = 1'b1;
		wait_clk(4);
		sda_pull = 1'b0;
		wait_clk(4);
	endtask
	task automatic put(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_cycle(b[i], r);
		bit_cycle(1'b1, r);
		acked = acked & !r;
	endtask

	// ==========================================
	// frames
	task automatic write_reg(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
		acked = 1'b1;
		start();
		put(a);
		put(c);
		put(d);
		stop();
	endtask
	task automatic write_mux(input logic [7:0] a, input logic [7:0] d);
		acked = 1'b1;
		start();
		put(a);
		put(d);
		stop();
	endtask
	task automatic read_reg(input logic [7:0] a, input logic [7:0] c);
		logic r;
		acked = 1'b1;
		start();
		put(a);
		put(c);
		start();
		put(a | 8'h01);
		for (int i = 7; i >= 0; i--)
			bit_cycle(1'b1, rdata[i]);
		bit_cycle(1'b1, r);
		stop();
	endtask
endmodule // management_host_model

`default_nettype wire

// file: tb/power_shelf_management_logic_tb.sv
// self-checking bench for the shelf management logic
`timescale 1ns/1ps
`default_nettype none

module power_shelf_management_logic_tb;
	logic clk, reset, scl, sda_pull, sda_line, sda_out, sda_oe, shelf_enable_n;
	logic power_good_n, input_good_n, shelf_alert_n, shelf_fault_latched;
	logic [2:0] addr_sw;
	logic [7:0] mux_ctl, ng, ny;
	logic [5:0] pg_n, al_n, in_n, ac_ok, oor, ot_sd, ov_sd, uv_sd, oc_sd, ot_w, fan;
	logic [5:0] en_n, ac_g, dc_g, dc_y;
	int n_fail = 0;
	int total_checks = 0;
	// open drain data line with pull-up
	assign sda_line = !(sda_pull || (sda_oe && !sda_out));

	power_shelf_management_logic #(.NUM_MODULES(6), .START_SETTLE_CYCLES(8),
		.BLINK_STEP_CYCLES(4)) uut (
		.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .shelf_enable_n(shelf_enable_n), .address_select_switch(addr_sw),
		.power_good_n(power_good_n), .input_good_n(input_good_n),
		.shelf_alert_n(shelf_alert_n), .shelf_fault_latched(shelf_fault_latched),
		.mux_channel_control(mux_ctl), .module_power_good_n(pg_n), .module_alert_n(al_n),
		.module_input_good_n(in_n), .module_ac_ok(ac_ok), .module_out_of_regulation(oor),
		.module_ot_shutdown(ot_sd), .module_ov_shutdown(ov_sd), .module_uv_shutdown(uv_sd),
		.module_oc_shutdown(oc_sd), .module_ot_warning(ot_w), .module_fan_minor_error(fan),
		.module_enable_n(en_n), .led_ac_green(ac_g), .led_dc_green(dc_g), .led_dc_yellow(dc_y));
	management_host_model host (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

	// ==========================================
	// helpers
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset();
		reset = 1'b1;
		wait_clk(3);
		reset = 1'b0;
		wait_clk(4);
	endtask
	// one blink period is 6 steps of 4 clocks, so any 24-clock window counts exactly
	task automatic count_lamps();
		ng = 8'h00;
		ny = 8'h00;
		wait_clk(8);
		repeat (24) begin
			@(negedge clk);
			ng = ng + 8'(dc_g[1]);
			ny = ny + 8'(dc_y[1]);
		end
	endtask

	// ==========================================
	// scenarios
	task automatic test_reset();
		check(16'(en_n), 16'h003F);
		check(16'(mux_ctl), 16'h0000);
		check(16'({power_good_n, input_good_n, shelf_alert_n, shelf_fault_latched}), 16'h000E);
		host.read_reg(8'h5E, 8'h01);
		check(16'(host.rdata), 16'h0080);
		host.read_reg(8'h5E, 8'h02);
		check(16'(host.rdata), 16'h0019);
		$display("test_reset done");
	endtask
	task automatic test_status();
		for (int m = 0; m < 6; m++) begin
			pg_n = ~(6'h01 << m);
			al_n = pg_n;
			in_n = pg_n;
			wait_clk(4);
			check(16'({power_good_n, input_good_n, shelf_alert_n}), 16'h0000);
			pg_n = 6'h3F;
			al_n = 6'h3F;
			in_n = 6'h3F;
			wait_clk(4);
			check(16'({power_good_n, input_good_n, shelf_alert_n}), 16'h0007);
		end
		$display("test_status done");
	endtask
	task automatic test_address();
		logic [7:0] a;
		for (int s = 0; s < 8; s++) begin
			addr_sw = 3'(s);
			wait_clk(4);
			a = 8'hE0 | {4'h0, 3'(s), 1'b0};
			host.write_mux(a, 8'hA0 + 8'(s));
			check(16'(host.acked), 16'h0001);
			check(16'(mux_ctl), 16'h00A0 + 16'(s));
			host.write_mux(a ^ 8'h02, 8'h55);
			check(16'(host.acked), 16'h0000);
			check(16'(mux_ctl), 16'h00A0 + 16'(s));
			host.read_reg(8'h50 | {4'h0, 3'(s), 1'b0}, 8'h01);
			check(16'({host.acked, host.rdata}), 16'h0180);
		end
		host.write_mux(8'hEE, 8'h3C);
		check(16'(mux_ctl), 16'h003C);
		host.read_reg(8'hEE, 8'h5A);
		check(16'({host.acked, host.rdata}), 16'h015A);
		$display("test_address done");
	endtask
	task automatic test_command();
		logic [7:0] cfg [5] = '{8'h01, 8'h11, 8'h1D, 8'h19, 8'h15};
		logic [15:0] off [5] = '{16'h0000, 16'h0000, 16'h003F, 16'h0000, 16'h003F};
		in_n = 6'h3E;
		wait_clk(16);
		check(16'(en_n), 16'h0000);
		host.write_reg(8'h5E, 8'h01, 8'h00);
		wait_clk(3);
		check(16'({host.acked, 2'h0, en_n}), 16'h013F);
		host.write_reg(8'h5E, 8'h01, 8'h80);
		wait_clk(3);
		check(16'(en_n), 16'h0000);
		host.write_reg(8'h5E, 8'h01, 8'h40);
		check(16'({host.acked, 2'h0, en_n}), 16'h0000);
		host.write_reg(8'h5E, 8'h03, 8'h00);
		check(16'({host.acked, 2'h0, en_n}), 16'h0000);
		for (int i = 0; i < 5; i++) begin
			host.write_reg(8'h5E, 8'h02, cfg[i]);
			check(16'(host.acked), 16'h0001);
			wait_clk(3);
			check(16'(en_n), off[i]);
			host.read_reg(8'h5E, 8'h02);
			check(16'(host.rdata), 16'(cfg[i]));
		end
		host.write_reg(8'h5E, 8'h02, 8'h42);
		check(16'(host.acked), 16'h0000);
		host.read_reg(8'h5E, 8'h02);
		check(16'(host.rdata), 16'h0015);
		shelf_enable_n = 1'b0;
		wait_clk(5);
		check(16'(en_n), 16'h0000);
		shelf_enable_n = 1'b1;
		wait_clk(5);
		check(16'(en_n), 16'h003F);
		do_reset();
		host.read_reg(8'h5E, 8'h02);
		check(16'(host.rdata), 16'h0019);
		check(16'(en_n), 16'h0000);
		in_n = 6'h3F;
		wait_clk(8);
		check(16'(en_n), 16'h003F);
		in_n = 6'h3E;
		wait_clk(16);
		$display("test_command done");
	endtask
	task automatic test_fault();
		for (int k = 0; k < 4; k++) begin
			{ot_sd[2], ov_sd[2], uv_sd[2], oc_sd[2]} = 4'h8 >> k;
			wait_clk(4);
			{ot_sd[2], ov_sd[2], uv_sd[2], oc_sd[2]} = 4'h0;
			wait_clk(8);
			check(16'({shelf_fault_latched, 2'h0, en_n}), 16'h013F);
			shelf_enable_n = 1'b0;
			wait_clk(6);
			check(16'({shelf_fault_latched, 2'h0, en_n}), 16'h0000);
			shelf_enable_n = 1'b1;
			wait_clk(4);
		end
		$display("test_fault done");
	endtask
	task automatic test_leds();
		ac_ok = 6'h3D;
		wait_clk(5);
		check(16'(ac_g), 16'h003D);
		ac_ok = 6'h3F;
		pg_n = 6'h3D;
		count_lamps();
		check({ng, ny}, 16'h1800);
		oor[1] = 1'b1;
		ot_w[1] = 1'b1;
		count_lamps();
		check({ng, ny}, 16'h0018);
		oor[1] = 1'b0;
		fan[1] = 1'b1;
		count_lamps();
		check({ng, ny}, 16'h0810);
		ot_w[1] = 1'b0;
		count_lamps();
		check({ng, ny}, 16'h0C0C);
		host.write_reg(8'h5E, 8'h01, 8'h00);
		count_lamps();
		check({ng, ny}, 16'h000C);
		host.write_reg(8'h5E, 8'h01, 8'h80);
		$display("test_leds done");
	endtask

	// ==========================================
	// main sequence and hang guard
	initial begin
		reset = 1'b1;
		shelf_enable_n = 1'b1;
		addr_sw = 3'h7;
		{pg_n, al_n, in_n, ac_ok} = {4{6'h3F}};
		{oor, ot_sd, ov_sd, uv_sd, oc_sd, ot_w, fan} = '0;
		do_reset();
		test_reset();
		test_status();
		test_address();
		test_command();
		test_fault();
		test_leds();
		print_verdict();
	end
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
endmodule // power_shelf_management_logic_tb

bind power_shelf_management_logic power_shelf_monitor #(.NUM_MODULES(NUM_MODULES)) mon (
	.clk(clk), .reset(reset), .power_good_n(power_good_n), .input_good_n(input_good_n),
	.shelf_alert_n(shelf_alert_n), .shelf_fault_latched(shelf_fault_latched),
	.module_power_good_n(module_power_good_n), .module_alert_n(module_alert_n),
	.module_input_good_n(module_input_good_n), .module_ac_ok(module_ac_ok),
	.module_ot_shutdown(module_ot_shutdown), .module_enable_n(module_enable_n),
	.led_ac_green(led_ac_green), .led_dc_green(led_dc_green), .led_dc_yellow(led_dc_yellow));

`default_nettype wire
